// ==== pkg/irscc_pkg.sv ====
// Constants for the infrared sensor conversion control block.
// Assumes a 125 MHz core clock and a same-clock converter front end.
package irscc_pkg;
  // Register pointers
  localparam logic [7:0] PTR_VOLTAGE = 8'h00;
  localparam logic [7:0] PTR_TEMP = 8'h01;
  localparam logic [7:0] PTR_CONFIG = 8'h02;
  // Reset values
  localparam logic [15:0] CFG_RESET = 16'h7400;
  localparam logic [13:0] TEMP_RESET = 14'h0000;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // Configuration and temperature field positions
  localparam int CFG_RST_BIT = 15;
  localparam int CFG_MODE_LSB = 12;
  localparam int CFG_RATE_LSB = 9;
  localparam int CFG_EN_BIT = 8;
  localparam int CFG_FLAG_BIT = 7;
  localparam int TEMP_LSB_POS = 2;
  // Mode and rate codes
  localparam logic [2:0] MODE_POWER_DOWN = 3'h0;
  localparam logic [2:0] MODE_CONTINUOUS = 3'h7;
  localparam logic [2:0] RATE_MAX = 3'h4;
  // One result step in degrees Celsius
  localparam real TEMP_STEP_DEGC = 0.03125;
  // Timing: fastest rate is one conversion per 250 ms
  localparam int CLK_KHZ = 125000;
  localparam int CONV_PERIOD_MS = 250;
  localparam int CONV_PERIOD_CYC = CONV_PERIOD_MS * CLK_KHZ;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_DELAY} irscc_state_t;
endpackage

// ==== rtl/irscc_top.sv ====
// Conversion control and result registers of an infrared thermopile sensor.
// Assumes a serial front end that turns bus frames into pointer, write and read
// strobes, and a converter that answers each sample request on the same clock.
// Behaviour
// RULE1: Temperature is 14 bits at 15:2, low zero
// RULE2: Result reads zero until first conversion completes
// RULE3: Twos complement, one step is 0.03125 C
// RULE4: Configuration register at pointer 02h, read/write
// RULE5: Bit 15 write resets, self clears
// RULE6: Software reset immediately restores all reset values
// RULE7: Mode 000 power-down, 111 continuous conversion
// RULE8: Power-down aborts conversion at once
// RULE9: Continuous: convert, then low-power delay, repeat
// RULE10: Rate field sets period and averaged samples
// RULE11: Bit 8 enables the data-ready pin
// RULE12: Bit 7 set when results are ready
// RULE13: Result read or config write clears flag
// RULE14: Data-ready pin is active-low open drain
// RULE15: Eight-bit pointer set by writes selects reads
// RULE16: Pin pulled low while enabled flag set
// RULE17: Bits 6:0 read zero; other modes reserved
`timescale 1ns/1ps
module irscc_top #(
  parameter int BASE_PERIOD_CYC = irscc_pkg::CONV_PERIOD_CYC
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PTR_WR,
  input wire logic [7:0] PTR_VAL,
  input wire logic DATA_WR,
  input wire logic [15:0] DATA_VAL,
  input wire logic RD_STB,
  input wire logic [15:0] VOLTAGE_IN,
  input wire logic SAMPLE_DONE,
  input wire logic [13:0] SAMPLE_TEMP,
  output logic [15:0] RD_DATA,
  output logic RD_VALID,
  output logic SAMPLE_REQ,
  output logic DATA_READY_FLAG_N_O,
  output logic DATA_READY_FLAG_N_OE
);
  if (BASE_PERIOD_CYC < 64 || BASE_PERIOD_CYC > 32'h0fffffff) begin : g_check
    $error("BASE_PERIOD_CYC out of range");
  end

  typedef struct packed {
    logic [7:0] ptr;
    logic [13:0] temp;
    logic [2:0] mode;
    logic [2:0] rate;
    logic en;
    logic flag;
    logic [15:0] rd_data;
    logic rd_valid;
    logic sample_req;
    logic data_ready_flag_oe;
    irscc_pkg::irscc_state_t st;
    logic [31:0] timer;
    logic [4:0] cnt;
    logic [17:0] acc;
  } irscc_regs_t;

  localparam irscc_regs_t REGS_RESET = '{
    ptr: irscc_pkg::PTR_RESET,
    temp: irscc_pkg::TEMP_RESET,
    mode: irscc_pkg::CFG_RESET[irscc_pkg::CFG_MODE_LSB +: 3],
    rate: irscc_pkg::CFG_RESET[irscc_pkg::CFG_RATE_LSB +: 3],
    en: irscc_pkg::CFG_RESET[irscc_pkg::CFG_EN_BIT],
    flag: irscc_pkg::CFG_RESET[irscc_pkg::CFG_FLAG_BIT],
    rd_data: 16'h0000,
    rd_valid: 1'b0,
    sample_req: 1'b0,
    data_ready_flag_oe: 1'b0,
    st: irscc_pkg::ST_IDLE,
    timer: 32'h00000000,
    cnt: 5'h00,
    acc: 18'h00000
  };

  irscc_regs_t q;
  irscc_regs_t next_q;
  logic [7:0] cur_ptr;
  logic [2:0] eff_rate;
  logic [4:0] last_idx;
  logic [17:0] sum;
  logic [17:0] avg;
  logic [15:0] cfg_word;
  logic sw_reset;
  logic cfg_wr;
  logic result_rd;
  logic conv_done;
  logic cont;

  always_comb begin
    next_q = q;
    // Pointer written in the same frame as data applies to that data
    cur_ptr = PTR_WR ? PTR_VAL : q.ptr; // RULE15
    cfg_wr = DATA_WR && cur_ptr == irscc_pkg::PTR_CONFIG;
    sw_reset = cfg_wr && DATA_VAL[irscc_pkg::CFG_RST_BIT]; // RULE5
    result_rd = RD_STB && (q.ptr == irscc_pkg::PTR_VOLTAGE || q.ptr == irscc_pkg::PTR_TEMP);
    // Reserved rate codes run at the slowest rate
    eff_rate = (q.rate > irscc_pkg::RATE_MAX) ? irscc_pkg::RATE_MAX : q.rate;
    last_idx = 5'((6'h01 << eff_rate) - 6'h01); // RULE10
    // Reserved mode codes behave as power-down
    cont = q.mode == irscc_pkg::MODE_CONTINUOUS; // RULE7 RULE17
    sum = q.acc + {{4{SAMPLE_TEMP[13]}}, SAMPLE_TEMP};
    avg = 18'($signed(sum) >>> eff_rate); // RULE3
    conv_done = 1'b0;
    cfg_word = '0; // RULE17
    cfg_word[irscc_pkg::CFG_MODE_LSB +: 3] = q.mode;
    cfg_word[irscc_pkg::CFG_RATE_LSB +: 3] = q.rate;
    cfg_word[irscc_pkg::CFG_EN_BIT] = q.en;
    cfg_word[irscc_pkg::CFG_FLAG_BIT] = q.flag; // RULE12

    next_q.sample_req = 1'b0;
    next_q.rd_valid = RD_STB;
    if (PTR_WR) begin
      next_q.ptr = PTR_VAL; // RULE15
    end
    if (RD_STB) begin
      unique case (q.ptr)
        irscc_pkg::PTR_VOLTAGE: next_q.rd_data = VOLTAGE_IN;
        irscc_pkg::PTR_TEMP: next_q.rd_data = {q.temp, 2'b00}; // RULE1
        irscc_pkg::PTR_CONFIG: next_q.rd_data = cfg_word; // RULE4
        default: next_q.rd_data = 16'h0000;
      endcase
    end
    if (cfg_wr) begin
      next_q.mode = DATA_VAL[irscc_pkg::CFG_MODE_LSB +: 3]; // RULE4
      next_q.rate = DATA_VAL[irscc_pkg::CFG_RATE_LSB +: 3];
      next_q.en = DATA_VAL[irscc_pkg::CFG_EN_BIT]; // RULE11
    end

    if (!cont) begin
      // Power-down drops the running conversion immediately
      next_q.st = irscc_pkg::ST_IDLE; // RULE8
      next_q.sample_req = 1'b0;
    end else begin
      if (q.st != irscc_pkg::ST_IDLE && q.timer != 32'h00000000) begin
        next_q.timer = q.timer - 32'h00000001;
      end
      unique case (q.st)
        irscc_pkg::ST_IDLE: begin
          next_q.st = irscc_pkg::ST_REQ; // RULE9
          next_q.timer = 32'((BASE_PERIOD_CYC << eff_rate) - 1); // RULE10
          next_q.cnt = 5'h00;
          next_q.acc = 18'h00000;
        end
        irscc_pkg::ST_REQ: begin
          next_q.sample_req = 1'b1;
          next_q.st = irscc_pkg::ST_WAIT;
        end
        irscc_pkg::ST_WAIT: begin
          if (SAMPLE_DONE) begin
            next_q.acc = sum;
            if (q.cnt >= last_idx) begin
              conv_done = 1'b1;
              next_q.temp = avg[13:0]; // RULE2
              next_q.st = irscc_pkg::ST_DELAY;
            end else begin
              next_q.cnt = q.cnt + 5'h01;
              next_q.st = irscc_pkg::ST_REQ;
            end
          end
        end
        irscc_pkg::ST_DELAY: begin
          // Low-power wait until the conversion period expires
          if (q.timer == 32'h00000000) begin
            next_q.st = irscc_pkg::ST_IDLE; // RULE9
          end
        end
      endcase
    end

    // A completion in the cycle of a clear keeps the flag set
    next_q.flag = conv_done || (q.flag && !(result_rd || cfg_wr)); // RULE12 RULE13
    next_q.data_ready_flag_oe = next_q.en && next_q.flag; // RULE16

    if (sw_reset) begin
      next_q = REGS_RESET; // RULE6
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      q <= REGS_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign RD_DATA = q.rd_data;
  assign RD_VALID = q.rd_valid;
  assign SAMPLE_REQ = q.sample_req;
  // Open drain: only ever pulls low, pull-up is external
  assign DATA_READY_FLAG_N_O = 1'b0; // RULE14
  assign DATA_READY_FLAG_N_OE = q.data_ready_flag_oe; // RULE16

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // Pointer and data may share a cycle, so use the decoded strobe
  sequence s_sw_reset;
    sw_reset;
  endsequence
  sequence s_temp_read;
    RD_STB && q.ptr == irscc_pkg::PTR_TEMP && !sw_reset;
  endsequence
  sequence s_finish;
    q.st == irscc_pkg::ST_WAIT && SAMPLE_DONE && cont && q.cnt >= last_idx && !sw_reset;
  endsequence

  AST_TEMP_LOW_ZERO: assert property (s_temp_read |=> RD_DATA[1:0] == 2'b00) // RULE1
    else $error("temperature low bits not zero");
  AST_SW_RESET_ALL: assert property (s_sw_reset |=> q.temp == 14'h0000 && q.mode == 3'h7
      && q.rate == 3'h2 && !q.en && !q.flag && q.ptr == 8'h00) // RULE6
    else $error("software reset did not restore registers");
  AST_RST_BIT_READS_ZERO: assert property (RD_STB && q.ptr == irscc_pkg::PTR_CONFIG
      |=> !RD_DATA[15] && RD_DATA[6:0] == 7'h00) // RULE5
    else $error("config reserved or reset bits read nonzero");
  AST_POWER_DOWN_ABORT: assert property (!cont |=> // RULE8
      q.st == irscc_pkg::ST_IDLE ##1 !SAMPLE_REQ)
    else $error("power-down did not abort conversion");
  // Enable and completion can land together, so judge the same cycle
  AST_PIN_DISABLED: assert property (!q.en |-> !DATA_READY_FLAG_N_OE) // RULE11
    else $error("data-ready pin driven while disabled");
  AST_FLAG_CLEARED: assert property (s_temp_read ##0 !conv_done |=> // RULE13
      !q.flag && !DATA_READY_FLAG_N_OE)
    else $error("data-ready flag not cleared by result read");
  AST_FLAG_SET: assert property (s_finish |=> q.flag && q.temp == $past(avg[13:0])
      ##1 (DATA_READY_FLAG_N_OE == q.en || $past(cfg_wr) || $past(result_rd))) // RULE12
    else $error("completion did not set data-ready");
  AST_CONT_RESTART: assert property (cont && q.st == irscc_pkg::ST_IDLE && !sw_reset
      ##1 (cont && !sw_reset) |=> SAMPLE_REQ) // RULE9
    else $error("continuous mode did not request a sample");
  AST_CFG_READBACK: assert property (RD_STB && q.ptr == irscc_pkg::PTR_CONFIG && !sw_reset
      |=> RD_DATA[14:8] == {$past(q.mode), $past(q.rate), $past(q.en)}) // RULE4
    else $error("config readback mismatch");
  AST_TEMP_ZERO_AT_START: assert property (s_sw_reset ##1 (q.st != irscc_pkg::ST_DELAY) [*3]
      |-> q.temp == 14'h0000) // RULE2
    else $error("result nonzero before first conversion");
endmodule

// ==== test/irscc_conv_model.sv ====
// Converter model: answers each sample request after a set delay.
// Assumes the block's clock and one request outstanding at a time.
`timescale 1ns/1ps
module irscc_conv_model (
  input wire logic clk,
  input wire logic req,
  input wire logic [13:0] value,
  input wire logic [7:0] delay,
  output logic done,
  output logic [13:0] temp
);
  int cnt = 0;
  logic [13:0] last = 14'h0000;
  always @(posedge clk) begin
    done <= 1'b0;
    // Stale sample would hide a capture on the wrong cycle
    temp <= ~last;
    if (req) begin
      cnt <= delay;
    end else if (cnt == 1) begin
      done <= 1'b1;
      temp <= value;
      last <= value;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ==== test/irscc_top_tb_top.sv ====
// Testbench: register access, conversions at every rate, power-down, software reset.
// Assumes the converter model is compiled before this file.
`timescale 1ns/1ps
module irscc_top_tb_top;
  logic clk = 0, srst = 1, ptr_wr = 0, data_wr = 0, rd_stb = 0;
  logic [7:0] ptr_val = 8'h00, dly = 8'h32;
  logic [15:0] data_val = 16'h0000, volt = 16'h0000, rd_data, cfg;
  logic [13:0] tval = 14'h0000, s_temp;
  logic rd_valid, s_req, s_done, data_ready_flag_o, data_ready_flag_oe;
  logic [15:0] expq[$];
  logic [31:0] rng = 32'h405c;
  int failures = 0, n_checks = 0, nreq = 0, n0, k;
  always #4 clk = ~clk;
  irscc_top #(.BASE_PERIOD_CYC(200)) irscc_top_inst (.CLK(clk), .SRST(srst),
    .PTR_WR(ptr_wr), .PTR_VAL(ptr_val), .DATA_WR(data_wr), .DATA_VAL(data_val),
    .RD_STB(rd_stb), .VOLTAGE_IN(volt), .SAMPLE_DONE(s_done), .SAMPLE_TEMP(s_temp),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .SAMPLE_REQ(s_req), .DATA_READY_FLAG_N_O(data_ready_flag_o),
    .DATA_READY_FLAG_N_OE(data_ready_flag_oe));
  irscc_conv_model irscc_conv_model_inst (.clk(clk), .req(s_req), .value(tval),
    .delay(dly), .done(s_done), .temp(s_temp));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) if (s_req === 1'b1) nreq <= nreq + 1;
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      chk(rd_data, expq.size() > 0 ? expq.pop_front() : 16'hxxxx);
    end
  end
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    ptr_wr = 1;
    ptr_val = p;
    data_wr = 1;
    data_val = d;
    @(negedge clk);
    ptr_wr = 0;
    data_wr = 0;
    // Idle cycle so a following pointer strobe is a fresh edge
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] p, input logic [15:0] exp);
    ptr_wr = 1;
    ptr_val = p;
    @(negedge clk);
    ptr_wr = 0;
    rd_stb = 1;
    expq.push_back(exp);
    @(negedge clk);
    rd_stb = 0;
  endtask
  // Pin clears on the same edge as the flag; skip one cycle before polling it
  task automatic wait_pin;
    @(negedge clk);
    for (k = 0; k < 8000 && data_ready_flag_oe !== 1'b1; k++) @(negedge clk);
    if (k == 8000) begin
      failures++;
      $display("BAD %0t data-ready pin wait timed out", $time);
      conclude();
    end
  endtask
  initial begin
    repeat (5) @(negedge clk);
    srst = 0;
    rd(8'h02, 16'h7400);
    rd(8'h01, 16'h0000);
    rd(8'h10, 16'h0000);
    wr(8'h02, 16'h71ff);
    rd(8'h02, 16'h7100);
    for (int i = 0; i < 5; i++) begin
      rng = xs(rng);
      tval = rng[13:0];
      volt = rng[31:16];
      dly = {5'h00, rng[18:16]} + 8'h01;
      cfg = {4'h7, 3'(i), 9'h100};
      wr(8'h02, cfg);
      wait_pin();
      rd(8'h02, cfg | 16'h0080);
      rd(8'h00, volt);
      // First completion may mix old and new samples; judge the next one
      wait_pin();
      rd(8'h01, {tval, 2'b00});
      rd(8'h02, cfg);
      chk({15'h0000, data_ready_flag_oe}, 16'h0000);
      chk({15'h0000, data_ready_flag_o}, 16'h0000);
    end
    wr(8'h02, 16'h0100);
    @(negedge clk);
    n0 = nreq;
    repeat (800) @(negedge clk);
    chk(16'(nreq), 16'(n0));
    rd(8'h02, 16'h0100);
    // Reserved mode and rate codes: no conversions, read back as written
    wr(8'h02, 16'h3e00);
    n0 = nreq;
    repeat (400) @(negedge clk);
    chk(16'(nreq), 16'(n0));
    rd(8'h02, 16'h3e00);
    dly = 8'h32;
    wr(8'h02, 16'h8100);
    rd(8'h02, 16'h7400);
    rd(8'h01, 16'h0000);
    repeat (3) @(negedge clk);
    conclude();
  end
endmodule
